// [vrld_pkg.sv]
package vrld_pkg;
  // Byte addresses; a control register sits at four times its index
  localparam logic [11:0] ADDR_REFERENCE_CONTROL = 12'h26c;
  localparam logic [11:0] ADDR_LOW_SUPPLY_DETECT_CONTROL = 12'h270;
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'h0a4;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h0a8;
  localparam logic [11:0] ADDR_AUX_CONTROL = 12'h0ac;
  // Printed register indices
  localparam logic [7:0] IDX_REFERENCE_CONTROL = 8'h9b;
  localparam logic [7:0] IDX_LOW_SUPPLY_DETECT_CONTROL = 8'h9c;
  // Field positions
  localparam int HIGH_REF_ENABLE_BIT = 7;
  localparam int LOW_REF_ENABLE_BIT = 6;
  localparam int HIGH_REF_OUTPUT_ENABLE_BIT = 5;
  localparam int LOW_REF_OUTPUT_ENABLE_BIT = 4;
  localparam int BANDGAP_STABLE_BIT = 5;
  localparam int DETECTOR_POWER_ENABLE_BIT = 4;
  localparam int LOW_SUPPLY_FLAG_BIT = 0;
  localparam int BANDGAP_STABLE_EVT_BIT = 1;
  localparam int LOW_SUPPLY_IRQ_ENABLE_BIT = 0;
  localparam int BROWNOUT_RESET_ENABLE_BIT = 0;
  // Reset values
  localparam logic [3:0] REFERENCE_CONTROL_RESET = 4'h0;
  localparam logic [3:0] TRIP_SELECT_RESET = 4'h5;
  localparam logic DETECTOR_POWER_ENABLE_RESET = 1'b0;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
  localparam logic BROWNOUT_RESET_ENABLE_RESET = 1'b0;
  // Trip select codes
  localparam logic [3:0] TRIP_LOWEST_VALID = 4'h4;
  localparam logic [3:0] TRIP_EXTERNAL = 4'hf;
endpackage : vrld_pkg

// [vrld_sync2.sv]
`timescale 1ns/10ps
`default_nettype none
module vrld_sync2 (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic d,
  output logic q
);
  logic stage1;
  logic next_stage1;
  logic next_q;

  always_comb begin
    next_stage1 = d;
    next_q = stage1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= 1'b0;
      q <= 1'b0;
    end else begin
      stage1 <= next_stage1;
      q <= next_q;
    end
  end
endmodule : vrld_sync2
`default_nettype wire

// [vrld_ctrl.sv]
// Behaviour
// - Bandgap powered while brownout, detector or either reference is enabled.
// - High reference enable bit 7 powers high gain amplifier.
// - Low reference enable bit 6 powers low gain amplifier.
// - Reference pin driven only when output enable and reference enable.
// - Read-only bandgap stable bit 5 set once bandgap is stable.
// - Low supply flag cannot set before bandgap stable.
// - Detector power enable bit 4 powers detector and requests bandgap.
// - Detector on and supply at or below trip sets flag.
// - Flag clear ignored while supply stays at or below trip.
// - Enabled low supply interrupt wakes device from sleep.
// - Four-bit trip select picks threshold; low codes reserved.
// - Code 1111 routes comparator to external detect input.
// - Low four bits of reference control read zero, ignore writes.
`timescale 1ns/10ps
`default_nettype none
module vrld_ctrl
  import vrld_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic trip_below,
  input wire logic bandgap_ready,
  output logic bandgap_power,
  output logic high_ref_amp_enable,
  output logic low_ref_amp_enable,
  output logic high_ref_pin_drive,
  output logic low_ref_pin_drive,
  output logic detector_power,
  output logic [3:0] trip_select_out,
  output logic external_detect_select,
  output logic irq,
  output logic wake
);
  ////////////////////////////////////////////////////////////////////////
  logic high_ref_enable;
  logic low_ref_enable;
  logic high_ref_output_enable;
  logic low_ref_output_enable;
  logic detector_power_enable;
  logic [3:0] trip_select;
  logic brownout_reset_enable;
  logic low_supply_flag;
  logic bandgap_stable_evt;
  logic [1:0] irq_mask;
  logic next_high_ref_enable;
  logic next_low_ref_enable;
  logic next_high_ref_output_enable;
  logic next_low_ref_output_enable;
  logic next_detector_power_enable;
  logic [3:0] next_trip_select;
  logic next_brownout_reset_enable;
  logic next_low_supply_flag;
  logic next_bandgap_stable_evt;
  logic [1:0] next_irq_mask;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic trip_sync;
  logic stable_sync;
  logic stable_prev;
  logic wr_en;
  logic rd_en;
  logic known_addr;
  logic bandgap_req;

  ////////////////////////////////////////////////////////////////////////
  // two-stage synchronisers
  vrld_sync2 u_trip_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(trip_below),
    .q(trip_sync)
  );

  vrld_sync2 u_stable_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(bandgap_ready),
    .q(stable_sync)
  );

  function automatic logic addr_is(input logic [11:0] a,
                                   input logic [11:0] ref_addr);
    return a == ref_addr;
  endfunction : addr_is

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign known_addr = addr_is(paddr, ADDR_REFERENCE_CONTROL) ||
                      addr_is(paddr, ADDR_LOW_SUPPLY_DETECT_CONTROL) ||
                      addr_is(paddr, ADDR_IRQ_STATUS) ||
                      addr_is(paddr, ADDR_IRQ_MASK) ||
                      addr_is(paddr, ADDR_AUX_CONTROL);
  assign bandgap_req = brownout_reset_enable || detector_power_enable ||
                       high_ref_enable || low_ref_enable;

  ////////////////////////////////////////////////////////////////////////
  // Register file and events
  always_comb begin
    next_high_ref_enable = high_ref_enable;
    next_low_ref_enable = low_ref_enable;
    next_high_ref_output_enable = high_ref_output_enable;
    next_low_ref_output_enable = low_ref_output_enable;
    next_detector_power_enable = detector_power_enable;
    next_trip_select = trip_select;
    next_brownout_reset_enable = brownout_reset_enable;
    next_irq_mask = irq_mask;
    next_low_supply_flag = low_supply_flag;
    next_bandgap_stable_evt = bandgap_stable_evt;
    if (wr_en) begin
      if (addr_is(paddr, ADDR_REFERENCE_CONTROL)) begin
        next_high_ref_enable = pwdata[HIGH_REF_ENABLE_BIT];
        next_low_ref_enable = pwdata[LOW_REF_ENABLE_BIT];
        next_high_ref_output_enable = pwdata[HIGH_REF_OUTPUT_ENABLE_BIT];
        next_low_ref_output_enable = pwdata[LOW_REF_OUTPUT_ENABLE_BIT];
      end
      if (addr_is(paddr, ADDR_LOW_SUPPLY_DETECT_CONTROL)) begin
        next_detector_power_enable = pwdata[DETECTOR_POWER_ENABLE_BIT];
        next_trip_select = pwdata[3:0];
      end
      if (addr_is(paddr, ADDR_IRQ_MASK)) begin
        next_irq_mask = pwdata[1:0];
      end
      if (addr_is(paddr, ADDR_AUX_CONTROL)) begin
        next_brownout_reset_enable = pwdata[BROWNOUT_RESET_ENABLE_BIT];
      end
      if (addr_is(paddr, ADDR_IRQ_STATUS)) begin
        if (pwdata[LOW_SUPPLY_FLAG_BIT] && !trip_sync) begin
          next_low_supply_flag = 1'b0;
        end
        if (pwdata[BANDGAP_STABLE_EVT_BIT]) begin
          next_bandgap_stable_evt = 1'b0;
        end
      end
    end
    if (detector_power_enable && stable_sync && trip_sync) begin
      next_low_supply_flag = 1'b1;
    end
    if (stable_sync && !stable_prev) begin
      next_bandgap_stable_evt = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_ref_enable <= REFERENCE_CONTROL_RESET[3];
      low_ref_enable <= REFERENCE_CONTROL_RESET[2];
      high_ref_output_enable <= REFERENCE_CONTROL_RESET[1];
      low_ref_output_enable <= REFERENCE_CONTROL_RESET[0];
      detector_power_enable <= DETECTOR_POWER_ENABLE_RESET;
      trip_select <= TRIP_SELECT_RESET;
      brownout_reset_enable <= BROWNOUT_RESET_ENABLE_RESET;
      irq_mask <= IRQ_MASK_RESET;
      low_supply_flag <= 1'b0;
      bandgap_stable_evt <= 1'b0;
      stable_prev <= 1'b0;
    end else begin
      high_ref_enable <= next_high_ref_enable;
      low_ref_enable <= next_low_ref_enable;
      high_ref_output_enable <= next_high_ref_output_enable;
      low_ref_output_enable <= next_low_ref_output_enable;
      detector_power_enable <= next_detector_power_enable;
      trip_select <= next_trip_select;
      brownout_reset_enable <= next_brownout_reset_enable;
      irq_mask <= next_irq_mask;
      low_supply_flag <= next_low_supply_flag;
      bandgap_stable_evt <= next_bandgap_stable_evt;
      stable_prev <= stable_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB read path; zero wait state, data registered in setup cycle
  always_comb begin
    next_prdata = 32'h0000_0000;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    if (psel && !penable) begin
      next_pready = 1'b1;
      next_pslverr = !known_addr;
    end
    if (rd_en) begin
      if (addr_is(paddr, ADDR_REFERENCE_CONTROL)) begin
        next_prdata[7:4] = {high_ref_enable, low_ref_enable,
                            high_ref_output_enable, low_ref_output_enable};
      end
      if (addr_is(paddr, ADDR_LOW_SUPPLY_DETECT_CONTROL)) begin
        next_prdata[BANDGAP_STABLE_BIT] = stable_sync;
        next_prdata[DETECTOR_POWER_ENABLE_BIT] = detector_power_enable;
        next_prdata[3:0] = trip_select;
      end
      if (addr_is(paddr, ADDR_IRQ_STATUS)) begin
        next_prdata[1:0] = {bandgap_stable_evt, low_supply_flag};
      end
      if (addr_is(paddr, ADDR_IRQ_MASK)) begin
        next_prdata[1:0] = irq_mask;
      end
      if (addr_is(paddr, ADDR_AUX_CONTROL)) begin
        next_prdata[BROWNOUT_RESET_ENABLE_BIT] = brownout_reset_enable;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Analog control outputs, all registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bandgap_power <= 1'b0;
      high_ref_amp_enable <= 1'b0;
      low_ref_amp_enable <= 1'b0;
      high_ref_pin_drive <= 1'b0;
      low_ref_pin_drive <= 1'b0;
      detector_power <= 1'b0;
      trip_select_out <= TRIP_SELECT_RESET;
      external_detect_select <= 1'b0;
      irq <= 1'b0;
      wake <= 1'b0;
    end else begin
      bandgap_power <= bandgap_req;
      high_ref_amp_enable <= high_ref_enable;
      low_ref_amp_enable <= low_ref_enable;
      high_ref_pin_drive <= high_ref_enable && high_ref_output_enable;
      low_ref_pin_drive <= low_ref_enable && low_ref_output_enable;
      detector_power <= detector_power_enable;
      trip_select_out <= trip_select;
      external_detect_select <= trip_select == TRIP_EXTERNAL;
      irq <= |({bandgap_stable_evt, low_supply_flag} & irq_mask);
      wake <= low_supply_flag && irq_mask[LOW_SUPPLY_IRQ_ENABLE_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  property p_bandgap_power;
    @(posedge pclk) disable iff (!presetn)
      ##1 bandgap_power == $past(bandgap_req);
  endproperty
  a_bandgap_power: assert property (p_bandgap_power)
    else $error("bandgap power does not follow its users");

  property p_pin_gate;
    @(posedge pclk) disable iff (!presetn)
      high_ref_pin_drive |-> $past(high_ref_enable);
  endproperty
  a_pin_gate: assert property (p_pin_gate)
    else $error("high pin driven while reference disabled");

  property p_flag_blocked;
    @(posedge pclk) disable iff (!presetn)
      !stable_sync && !low_supply_flag |=> !low_supply_flag;
  endproperty
  a_flag_blocked: assert property (p_flag_blocked)
    else $error("flag set before bandgap stable");

  property p_flag_sets;
    @(posedge pclk) disable iff (!presetn)
      detector_power_enable && stable_sync && trip_sync |=> low_supply_flag;
  endproperty
  a_flag_sets: assert property (p_flag_sets)
    else $error("low supply flag not set");

  property p_clear_refused;
    @(posedge pclk) disable iff (!presetn)
      low_supply_flag && trip_sync |=> low_supply_flag;
  endproperty
  a_clear_refused: assert property (p_clear_refused)
    else $error("flag cleared while supply still low");

  property p_wake;
    @(posedge pclk) disable iff (!presetn)
      low_supply_flag && irq_mask[0] |=> wake && irq;
  endproperty
  a_wake: assert property (p_wake)
    else $error("enabled flag gives no wake");

  property p_external;
    @(posedge pclk) disable iff (!presetn)
      trip_select == TRIP_EXTERNAL |=> external_detect_select;
  endproperty
  a_external: assert property (p_external)
    else $error("external input not selected");

  property p_ref_low_nibble;
    @(posedge pclk) disable iff (!presetn)
      rd_en && addr_is(paddr, ADDR_REFERENCE_CONTROL) |=> prdata[3:0] == 4'h0;
  endproperty
  a_ref_low_nibble: assert property (p_ref_low_nibble)
    else $error("reserved bits read nonzero");

  property p_stable_status;
    @(posedge pclk) disable iff (!presetn)
      rd_en && addr_is(paddr, ADDR_LOW_SUPPLY_DETECT_CONTROL)
        |=> prdata[BANDGAP_STABLE_BIT] == $past(stable_sync);
  endproperty
  a_stable_status: assert property (p_stable_status)
    else $error("bandgap stable status wrong");
endmodule : vrld_ctrl
`default_nettype wire

// [vrld_analog_model.sv]
`timescale 1ns/10ps
`default_nettype none
module vrld_analog_model #(
  parameter int STARTUP = 40
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic bandgap_power,
  input wire logic detector_power,
  input wire logic [3:0] trip_select_out,
  input wire logic external_detect_select,
  input wire logic [15:0] supply_mv,
  input wire logic ext_below,
  output logic trip_below,
  output logic bandgap_ready
);
  int cnt;
  logic [15:0] trip_mv;
  always_comb begin
    case (trip_select_out)
      4'h4: trip_mv = 16'h09c4;
      4'h5: trip_mv = 16'h0a8c;
      4'h6: trip_mv = 16'h0af0;
      4'h7: trip_mv = 16'h0bb8;
      4'h8: trip_mv = 16'h0ce4;
      4'h9: trip_mv = 16'h0dac;
      4'ha: trip_mv = 16'h0e10;
      4'hb: trip_mv = 16'h0ed8;
      4'hc: trip_mv = 16'h0fa0;
      4'hd: trip_mv = 16'h1068;
      4'he: trip_mv = 16'h1194;
      // Reserved codes trip at any supply
      default: trip_mv = 16'hffff;
    endcase
  end
  // Ready only after a full startup; lost at once when unpowered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      bandgap_ready <= 1'b0;
      trip_below <= 1'b0;
    end else begin
      cnt <= bandgap_power ? cnt + 1 : 0;
      bandgap_ready <= bandgap_power && cnt >= STARTUP;
      // external input replaces internal threshold
      // Unpowered comparator idles low, no stale trip after power-off
      if (!detector_power)
        trip_below <= 1'b0;
      else if (external_detect_select)
        trip_below <= ext_below;
      else
        trip_below <= supply_mv <= trip_mv;
    end
  end
endmodule : vrld_analog_model
`default_nettype wire

// [testbench.sv]
`timescale 1ns/10ps
`default_nettype none
module testbench
  import vrld_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, ext_below = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, d;
  logic [15:0] supply_mv = 16'h1388;
  logic pready, pslverr, trip_below, bandgap_ready, bandgap_power, e;
  logic high_ref_amp_enable, low_ref_amp_enable, high_ref_pin_drive;
  logic low_ref_pin_drive, detector_power, external_detect_select, irq, wake;
  logic [3:0] trip_select_out;
  int errors = 0, n_tests = 0, i;
  typedef struct {logic [7:0] wd; logic [7:0] rd; logic [4:0] outs;} vrld_row_s;
  vrld_row_s rows [8] = '{'{8'h80, 8'h80, 5'h18}, '{8'h20, 8'h20, 5'h00},
    '{8'ha0, 8'ha0, 5'h1a}, '{8'h50, 8'h50, 5'h15}, '{8'h10, 8'h10, 5'h00},
    '{8'h40, 8'h40, 5'h14}, '{8'hff, 8'hf0, 5'h1f}, '{8'h00, 8'h00, 5'h00}};

  always #25 pclk = ~pclk;

  vrld_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trip_below(trip_below), .bandgap_ready(bandgap_ready),
    .bandgap_power(bandgap_power), .high_ref_amp_enable(high_ref_amp_enable),
    .low_ref_amp_enable(low_ref_amp_enable),
    .high_ref_pin_drive(high_ref_pin_drive),
    .low_ref_pin_drive(low_ref_pin_drive), .detector_power(detector_power),
    .trip_select_out(trip_select_out),
    .external_detect_select(external_detect_select), .irq(irq), .wake(wake));

  vrld_analog_model i_model (.pclk(pclk), .presetn(presetn),
    .bandgap_power(bandgap_power), .detector_power(detector_power),
    .trip_select_out(trip_select_out),
    .external_detect_select(external_detect_select), .supply_mv(supply_mv),
    .ext_below(ext_below), .trip_below(trip_below),
    .bandgap_ready(bandgap_ready));

  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_out(input logic [7:0] got, input logic [7:0] exp);
    chk({24'h0, got}, {24'h0, exp});
  endtask : chk_out

  // Master holds the request until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      errors++;
      close_out();
    end
  endtask : apb

  task automatic reg_wr(input logic [11:0] a, input logic [31:0] wd);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, wd, rd, err);
  endtask : reg_wr

  task automatic reg_rd(input logic [11:0] a, output logic [31:0] rd);
    logic err;
    apb(1'b0, a, 32'h0, rd, err);
  endtask : reg_rd

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #(50 * 20000);
    errors++;
    close_out();
  end

  initial begin
    repeat (4) @(posedge pclk);
    chk_out({4'h0, trip_select_out}, {4'h0, TRIP_SELECT_RESET});
    presetn <= 1'b1;
    reg_rd(ADDR_REFERENCE_CONTROL, d);
    chk(d, 32'h0);
    reg_rd(ADDR_LOW_SUPPLY_DETECT_CONTROL, d);
    chk(d, 32'h5);
    reg_rd(ADDR_IRQ_MASK, d);
    chk(d, 32'h0);
    $display("test reset done");
    for (i = 0; i < 8; i++) begin
      reg_wr(ADDR_REFERENCE_CONTROL, {24'h0, rows[i].wd});
      reg_rd(ADDR_REFERENCE_CONTROL, d);
      chk(d, {24'h0, rows[i].rd});
      repeat (2) @(posedge pclk);
      chk_out({3'h0, bandgap_power, high_ref_amp_enable, low_ref_amp_enable,
        high_ref_pin_drive, low_ref_pin_drive}, {3'h0, rows[i].outs});
    end
    $display("test reference table done");
    for (i = 4; i < 16; i++) begin
      reg_wr(ADDR_LOW_SUPPLY_DETECT_CONTROL, 32'(i));
      repeat (2) @(posedge pclk);
      chk_out({3'h0, external_detect_select, trip_select_out},
              {3'h0, i == 15, 4'(i)});
    end
    reg_rd(ADDR_IRQ_STATUS, d);
    chk(d, 32'h0);
    $display("test trip codes done");
    apb(1'b0, 12'h0fc, 32'h0, d, e);
    chk(d, 32'h0);
    chk_out({7'h0, e}, 8'h01);
    reg_wr(ADDR_AUX_CONTROL, 32'h1);
    repeat (2) @(posedge pclk);
    chk_out({7'h0, bandgap_power}, 8'h01);
    reg_wr(ADDR_AUX_CONTROL, 32'h0);
    repeat (2) @(posedge pclk);
    chk_out({7'h0, bandgap_power}, 8'h00);
    $display("test unmapped and brownout done");
    reg_wr(ADDR_LOW_SUPPLY_DETECT_CONTROL, 32'h8);
    reg_wr(ADDR_LOW_SUPPLY_DETECT_CONTROL, 32'h18);
    supply_mv <= 16'h0bb8;
    repeat (2) @(posedge pclk);
    chk_out({6'h0, detector_power, bandgap_power}, 8'h03);
    reg_rd(ADDR_IRQ_STATUS, d);
    chk(d & 32'h1, 32'h0);
    d = 32'h0;
    // poll stable before relying on it
    for (i = 0; i < 40 && d[BANDGAP_STABLE_BIT] !== 1'b1; i++)
      reg_rd(ADDR_LOW_SUPPLY_DETECT_CONTROL, d);
    chk(d, 32'h38);
    repeat (6) @(posedge pclk);
    reg_rd(ADDR_IRQ_STATUS, d);
    chk(d & 32'h1, 32'h1);
    chk_out({6'h0, irq, wake}, 8'h00);
    reg_wr(ADDR_IRQ_MASK, 32'h1);
    repeat (2) @(posedge pclk);
    chk_out({6'h0, irq, wake}, 8'h03);
    reg_wr(ADDR_IRQ_STATUS, 32'h1);
    reg_rd(ADDR_IRQ_STATUS, d);
    chk(d & 32'h1, 32'h1);
    reg_wr(ADDR_IRQ_MASK, 32'h0);
    repeat (2) @(posedge pclk);
    chk_out({6'h0, irq, wake}, 8'h00);
    supply_mv <= 16'h1388;
    repeat (6) @(posedge pclk);
    reg_wr(ADDR_IRQ_STATUS, 32'h3);
    reg_rd(ADDR_IRQ_STATUS, d);
    chk(d, 32'h0);
    $display("test low supply event done");
    reg_wr(ADDR_LOW_SUPPLY_DETECT_CONTROL, 32'h0f);
    reg_wr(ADDR_LOW_SUPPLY_DETECT_CONTROL, 32'h1f);
    ext_below <= 1'b1;
    repeat (6) @(posedge pclk);
    reg_rd(ADDR_IRQ_STATUS, d);
    chk(d & 32'h1, 32'h0);
    d = 32'h0;
    // bandgap restarts after the detector was off
    for (i = 0; i < 40 && d[BANDGAP_STABLE_BIT] !== 1'b1; i++)
      reg_rd(ADDR_LOW_SUPPLY_DETECT_CONTROL, d);
    chk(d, 32'h3f);
    repeat (6) @(posedge pclk);
    reg_rd(ADDR_IRQ_STATUS, d);
    chk(d & 32'h1, 32'h1);
    reg_wr(ADDR_IRQ_MASK, 32'h2);
    repeat (2) @(posedge pclk);
    chk_out({6'h0, irq, wake}, 8'h02);
    $display("test external input done");
    close_out();
  end
endmodule : testbench
`default_nettype wire
